// File: src/icc_pkg.sv
// Notes on behaviour
// - on a qualifying pin event, record the selected 16-bit timebase count
// - falling-edge mode captures on every high-to-low transition
// - rising-edge mode captures on every low-to-high transition
// - both-edges mode captures on every transition
// - divide-by-four mode captures on each fourth rising edge
// - mode 101 captures on each sixteenth rising edge
// - mode 111 gives a rising-edge interrupt only while asleep or idle, no capture
// - mode 110 is unused and keeps the channel disabled
// - timebase select one picks first count, zero picks second count
// - captures-per-interrupt code 00..11 gives interrupt every 1..4 captures
// - captured values sit in a four-word fifo, read out in order
// - read-only overflow flag reads one after a capture overflow
// - read-only not-empty flag is one while a captured value remains unread
// - pin activity can wake the device from sleep and idle
package icc_pkg;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CONTROL  = 12'h000;
    localparam logic [11:0] ADDR_BUFFER   = 12'h004;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTL_MODE_LSB   = 0;
    localparam int CTL_BNE_BIT    = 3;
    localparam int CTL_OV_BIT     = 4;
    localparam int CTL_CPI_LSB    = 5;
    localparam int CTL_TBSEL_BIT  = 7;
    localparam int CTL_SIDL_BIT   = 13;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] CTL_WMASK = 16'h20E7;

    // ------------------------------------------------------------
    // mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_BOTH   = 3'h1;
    localparam logic [2:0] MODE_FALL   = 3'h2;
    localparam logic [2:0] MODE_RISE   = 3'h3;
    localparam logic [2:0] MODE_RISE4  = 3'h4;
    localparam logic [2:0] MODE_RISE16 = 3'h5;
    localparam logic [2:0] MODE_UNUSED = 3'h6;
    localparam logic [2:0] MODE_WAKE   = 3'h7;

    // ------------------------------------------------------------
    // interrupt status bits, fifo size
    // ------------------------------------------------------------
    localparam int IRQ_CAPTURE = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_WAKE    = 2;
    localparam int IRQ_BITS    = 3;
    localparam int FIFO_DEPTH  = 4;
    localparam int FIFO_AW     = 2;

endpackage

// File: src/icc_cap_if.sv
`timescale 1ns/10ps
`default_nettype none
interface icc_cap_if;
    logic        push;
    logic [15:0] wdata;
    logic        pop;
    logic [15:0] rdata;
    logic        not_empty;
    logic        full;

    modport owner (output push, output wdata, output pop,
                   input rdata, input not_empty, input full);
    modport fifo  (input push, input wdata, input pop,
                   output rdata, output not_empty, output full);
endinterface
`default_nettype wire

// File: src/icc_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module icc_fifo (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // push and pop
    icc_cap_if.fifo   cap
);
    logic [15:0] mem_reg [icc_pkg::FIFO_DEPTH];
    logic [15:0] mem_next [icc_pkg::FIFO_DEPTH];
    logic [icc_pkg::FIFO_AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
    logic [icc_pkg::FIFO_AW:0]   cnt_reg, cnt_next;
    logic do_push, do_pop;

    // a push into a full fifo is dropped here
    assign do_push = cap.push && (cnt_reg != 3'(icc_pkg::FIFO_DEPTH));
    assign do_pop  = cap.pop && (cnt_reg != 3'd0);

    always_comb begin
        mem_next = mem_reg;
        wr_next  = wr_reg;
        rd_next  = rd_reg;
        cnt_next = cnt_reg;
        if (do_push) begin
            mem_next[wr_reg] = cap.wdata;
            wr_next = wr_reg + 2'd1;
        end
        if (do_pop) begin
            rd_next = rd_reg + 2'd1;
        end
        cnt_next = cnt_reg + {2'd0, do_push} - {2'd0, do_pop};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < icc_pkg::FIFO_DEPTH; i++) begin
                mem_reg[i] <= 16'h0000;
            end
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    assign cap.rdata     = mem_reg[rd_reg];
    assign cap.not_empty = (cnt_reg != 3'd0);
    assign cap.full      = (cnt_reg == 3'(icc_pkg::FIFO_DEPTH));
endmodule // icc_fifo
`default_nettype wire

// File: src/icc_edge.sv
`timescale 1ns/10ps
`default_nettype none
module icc_edge (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // raw pin and mode
    input  wire logic       pin_async,
    input  wire logic [2:0] mode,
    input  wire logic       asleep,
    // results
    output logic            capture_evt,
    output logic            wake_evt
);
    logic s1_reg, s2_reg, s3_reg;
    logic [3:0] pre_reg, pre_next;
    logic [2:0] mode_q_reg;
    logic rise, fall, hit;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_reg     <= 1'b0;
            s2_reg     <= 1'b0;
            s3_reg     <= 1'b0;
            pre_reg    <= 4'h0;
            mode_q_reg <= 3'h0;
        end else begin
            s1_reg     <= pin_async;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            pre_reg    <= pre_next;
            mode_q_reg <= mode;
        end
    end

    assign rise = s2_reg && !s3_reg;
    assign fall = !s2_reg && s3_reg;

    always_comb begin
        pre_next = pre_reg;
        hit      = 1'b0;
        // prescaler restarts whenever the mode changes
        if (mode != mode_q_reg) begin
            pre_next = 4'h0;
        end else begin
            case (mode)
                icc_pkg::MODE_BOTH:  hit = rise || fall;
                icc_pkg::MODE_FALL:  hit = fall;
                icc_pkg::MODE_RISE:  hit = rise;
                icc_pkg::MODE_RISE4: begin
                    if (rise) begin
                        pre_next = (pre_reg == 4'h3) ? 4'h0 : pre_reg + 4'h1;
                        hit = (pre_reg == 4'h3);
                    end
                end
                icc_pkg::MODE_RISE16: begin
                    if (rise) begin
                        pre_next = pre_reg + 4'h1;
                        hit = (pre_reg == 4'hF);
                    end
                end
                default: hit = 1'b0;
            endcase
        end
    end

    assign capture_evt = hit;
    assign wake_evt = (mode == icc_pkg::MODE_WAKE) && asleep && rise;
endmodule // icc_edge
`default_nettype wire

// File: src/icc_top.sv
`timescale 1ns/10ps
`default_nettype none
module icc_top (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // capture pin and timebases
    input  wire logic        capture_input_pin,
    input  wire logic [15:0] first_timebase_count,
    input  wire logic [15:0] second_timebase_count,
    // power state
    input  wire logic        cpu_sleep,
    input  wire logic        cpu_idle,
    // events out
    output logic             wake_request,
    output logic             irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    icc_cap_if cap ();
    logic [15:0] ctl_reg, ctl_next;
    logic        ov_reg, ov_next;
    logic [1:0]  cpi_cnt_reg, cpi_cnt_next;
    logic [2:0]  stat_reg, stat_next;
    logic [2:0]  mask_reg, mask_next;
    logic        irq_reg, wake_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic        wr_pend_reg;
    logic [11:0] wr_addr_reg;
    logic        rd_pop_next;
    logic        capture_evt, wake_evt, rate_hit;
    logic        addr_ok, asleep;
    logic [2:0]  mode;
    logic [1:0]  cpi;
    logic        stopped;

    assign mode = ctl_reg[icc_pkg::CTL_MODE_LSB +: 3];
    assign cpi  = ctl_reg[icc_pkg::CTL_CPI_LSB +: 2];
    assign asleep  = cpu_sleep || cpu_idle;
    // stop-in-idle halts capturing while the cpu idles; the wake-only
    // mode ignores every other control field, so it keeps running
    assign stopped = ctl_reg[icc_pkg::CTL_SIDL_BIT] && cpu_idle &&
                     (mode != icc_pkg::MODE_WAKE);

    icc_edge u_edge (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .pin_async   (capture_input_pin),
        .mode        (stopped ? icc_pkg::MODE_OFF : mode),
        .asleep      (asleep),
        .capture_evt (capture_evt),
        .wake_evt    (wake_evt)
    );

    icc_fifo u_fifo (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cap     (cap.fifo)
    );

    // ------------------------------------------------------------
    // capture path
    // ------------------------------------------------------------
    assign cap.wdata = ctl_reg[icc_pkg::CTL_TBSEL_BIT] ?
                       first_timebase_count : second_timebase_count;
    assign cap.push  = capture_evt;
    // pop as the read is taken, so a back-to-back read sees the next entry
    assign cap.pop   = rd_pop_next;
    // interrupt after cpi+1 captures actually stored
    assign rate_hit  = capture_evt && !cap.full && (cpi_cnt_reg == cpi);

    // ------------------------------------------------------------
    // ahb-lite decode
    // ------------------------------------------------------------
    assign addr_ok = hsel && hready && htrans[1];

    always_comb begin
        ctl_next     = ctl_reg;
        ov_next      = ov_reg;
        cpi_cnt_next = cpi_cnt_reg;
        stat_next    = stat_reg;
        mask_next    = mask_reg;
        rdata_next   = 32'h0000_0000;
        rd_pop_next  = 1'b0;

        // write data phase; register writes precede the event set below
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                icc_pkg::ADDR_CONTROL: begin
                    ctl_next = (ctl_reg & ~icc_pkg::CTL_WMASK) |
                               (hwdata[15:0] & icc_pkg::CTL_WMASK);
                    // turning the channel off clears overflow and rate
                    if (hwdata[2:0] == icc_pkg::MODE_OFF) begin
                        ov_next      = 1'b0;
                        cpi_cnt_next = 2'd0;
                    end
                end
                icc_pkg::ADDR_IRQ_STAT: stat_next = stat_reg & ~hwdata[2:0];
                icc_pkg::ADDR_IRQ_MASK: mask_next = hwdata[2:0];
                default: ;
            endcase
        end

        // read address phase: data registered for the data phase; reads
        // use the post-write values so a read right after a write is fresh
        if (addr_ok && !hwrite) begin
            case (haddr)
                icc_pkg::ADDR_CONTROL: begin
                    rdata_next[15:0] = ctl_next;
                    rdata_next[icc_pkg::CTL_OV_BIT]  = ov_next;
                    rdata_next[icc_pkg::CTL_BNE_BIT] = cap.not_empty;
                end
                icc_pkg::ADDR_BUFFER: begin
                    rdata_next[15:0] = cap.rdata;
                    rd_pop_next = cap.not_empty;
                end
                icc_pkg::ADDR_IRQ_STAT: rdata_next[2:0] = stat_next;
                icc_pkg::ADDR_IRQ_MASK: rdata_next[2:0] = mask_next;
                default: rdata_next = 32'h0000_0000;
            endcase
        end

        // hardware events; set wins over a same-cycle clear
        if (capture_evt) begin
            if (cap.full) begin
                ov_next = 1'b1;
                stat_next[icc_pkg::IRQ_OVERRUN] = 1'b1;
            end else begin
                cpi_cnt_next = (cpi_cnt_reg == cpi) ? 2'd0
                                                    : cpi_cnt_reg + 2'd1;
            end
        end
        if (rate_hit) begin
            stat_next[icc_pkg::IRQ_CAPTURE] = 1'b1;
        end
        if (wake_evt) begin
            stat_next[icc_pkg::IRQ_WAKE] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_reg     <= icc_pkg::CTL_RESET;
            ov_reg      <= 1'b0;
            cpi_cnt_reg <= 2'd0;
            stat_reg    <= 3'h0;
            mask_reg    <= 3'h0;
            rdata_reg   <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            irq_reg     <= 1'b0;
            wake_reg    <= 1'b0;
        end else begin
            ctl_reg     <= ctl_next;
            ov_reg      <= ov_next;
            cpi_cnt_reg <= cpi_cnt_next;
            stat_reg    <= stat_next;
            mask_reg    <= mask_next;
            rdata_reg   <= rdata_next;
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr;
            irq_reg     <= |(stat_next & mask_next);
            wake_reg    <= wake_evt || (asleep && capture_evt);
        end
    end

    // zero-wait slave: always ready, always okay
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = rdata_reg;
    assign irq          = irq_reg;
    assign wake_request = wake_reg;
endmodule // icc_top
`default_nettype wire

// File: sim/icc_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module icc_pin_model (
    // clock
    input  wire logic hclk,
    // capture pin
    output var logic  pin
);
    // ----------
    // pulse trains
    // ----------
    // the pin idles low, so each pulse gives one rise and one fall;
    // w sets the pace, short for a prompt source and long for a slow one
    initial pin = 1'b0;
    task automatic pulses(input int n, input int w);
        for (int p = 0; p < n; p++) begin
            repeat (w) @(posedge hclk);
            pin <= 1'b1;
            repeat (w) @(posedge hclk);
            pin <= 1'b0;
        end
    endtask
endmodule // icc_pin_model
`default_nettype wire

// File: sim/icc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module icc_monitor (
    // bus
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    // pin and events
    input wire logic        capture_input_pin,
    input wire logic        cpu_sleep,
    input wire logic        cpu_idle,
    input wire logic        wake_request,
    input wire logic        irq
);
    // ----------
    // data phase and event ages
    // ----------
    logic        rd_dp_reg;
    logic [11:0] dp_addr_reg;
    logic        pin_last_reg;
    logic [3:0]  pin_age_reg;
    logic [3:0]  wr_age_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_dp_reg    <= 1'b0;
            dp_addr_reg  <= 12'h000;
            pin_last_reg <= 1'b0;
            pin_age_reg  <= 4'hf;
            wr_age_reg   <= 4'hf;
        end else begin
            rd_dp_reg    <= hsel && hready && htrans[1] && !hwrite;
            dp_addr_reg  <= haddr;
            pin_last_reg <= capture_input_pin;
            // ages saturate so an old cause never looks fresh again
            pin_age_reg  <= (capture_input_pin != pin_last_reg) ? 4'h0 :
                            (pin_age_reg == 4'hf) ? 4'hf : pin_age_reg + 4'h1;
            wr_age_reg   <= (hsel && hready && htrans[1] && hwrite) ? 4'h0 :
                            (wr_age_reg == 4'hf) ? 4'hf : wr_age_reg + 4'h1;
        end
    end

    // ----------
    // properties
    // ----------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_ctl_rd;
        rd_dp_reg && dp_addr_reg == 12'h000;
    endsequence
    property p_rdata_idle;
        !rd_dp_reg |-> hrdata == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside data phase");
    property p_narrow;
        rd_dp_reg |-> hrdata[31:16] == 16'h0000;
    endproperty
    a_narrow: assert property (p_narrow)
        else $error("read data wider than 16 bits");
    property p_ctl_layout;
        s_ctl_rd |-> (hrdata & 32'hffff_df00) == 32'h0000_0000;
    endproperty
    a_ctl_layout: assert property (p_ctl_layout)
        else $error("control reads a reserved bit set");
    property p_wake_pulse;
        wake_request |=> !wake_request;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake request longer than one cycle");
    property p_wake_asleep;
        wake_request |-> $past(cpu_sleep) || $past(cpu_idle);
    endproperty
    a_wake_asleep: assert property (p_wake_asleep)
        else $error("wake request while awake");
    property p_wake_cause;
        wake_request |-> pin_age_reg <= 4'h8;
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake request without pin activity");
    property p_irq_fall;
        $fell(irq) |-> wr_age_reg <= 4'h3;
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
    property p_irq_rise;
        $rose(irq) |-> pin_age_reg <= 4'ha || wr_age_reg <= 4'h3;
    endproperty
    a_irq_rise: assert property (p_irq_rise)
        else $error("irq rose without a cause");
endmodule // icc_monitor
bind icc_top icc_monitor i_mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .capture_input_pin(capture_input_pin), .cpu_sleep(cpu_sleep),
    .cpu_idle(cpu_idle), .wake_request(wake_request), .irq(irq)
);
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pin;
    logic [15:0] cnt_a = 16'h0000;
    logic [15:0] cnt_b = 16'h0000;
    logic        cpu_sleep = 1'b0;
    logic        cpu_idle = 1'b0;
    logic        wake;
    logic        irq;
    logic [31:0] rd;
    logic [11:0] r;
    int          miscompares = 0;
    int          comparisons = 0;
    int          wakes = 0;
    // mode, timebase select, pulses, captures expected
    logic [11:0] rows [8] = '{
        {3'h1, 1'h1, 5'h02, 3'h4},
        {3'h2, 1'h0, 5'h03, 3'h3},
        {3'h3, 1'h0, 5'h03, 3'h3},
        {3'h4, 1'h1, 5'h08, 3'h2},
        {3'h5, 1'h0, 5'h10, 3'h1},
        {3'h6, 1'h1, 5'h03, 3'h0},
        {3'h0, 1'h1, 5'h02, 3'h0},
        {3'h7, 1'h0, 5'h02, 3'h0}};

    icc_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .capture_input_pin(pin),
        .first_timebase_count(cnt_a), .second_timebase_count(cnt_b),
        .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .wake_request(wake), .irq(irq)
    );
    icc_pin_model i_pin (.hclk(hclk), .pin(pin));

    initial forever #25 hclk = ~hclk;
    always @(posedge hclk) if (wake === 1'b1) wakes++;

    // ----------
    // bus and checking tasks
    // ----------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    task automatic conclude;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge hclk);
        miscompares++;
        conclude();
    end

    // ----------
    // main sequence
    // ----------
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'({irq, wake, hresp, hreadyout}), 32'h0000_0001);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_0000);
        rchk(icc_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
        rchk(icc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_ffff);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_20e7);
        xfer(1'b1, 12'h010, 32'hffff_ffff);
        rchk(12'h010, 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            cnt_a <= 16'ha000 + 16'(i);
            cnt_b <= 16'hb000 + 16'(i);
            xfer(1'b1, icc_pkg::ADDR_CONTROL, {24'h0, r[8], 4'h0, r[11:9]});
            i_pin.pulses(int'(r[7:3]), 3 + 3 * (i % 2));
            repeat (10) @(posedge hclk);
            rchk(icc_pkg::ADDR_CONTROL, {24'h0, r[8], 3'h0, r[2:0] != 3'h0,
                 r[11:9]});
            for (int k = 0; k < int'(r[2:0]); k++)
                rchk(icc_pkg::ADDR_BUFFER, {16'h0, r[8] ? cnt_a : cnt_b});
            rchk(icc_pkg::ADDR_CONTROL, {24'h0, r[8], 4'h0, r[11:9]});
        end
        // fifo overrun: the fifth capture is dropped, order is kept
        xfer(1'b1, icc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0083);
        for (int p = 0; p < 5; p++) begin
            cnt_a <= 16'hc000 + 16'(p);
            i_pin.pulses(1, 6);
        end
        repeat (10) @(posedge hclk);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_009b);
        chk(32'(irq), 32'h0000_0000);
        rchk(icc_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
        for (int p = 0; p < 4; p++)
            rchk(icc_pkg::ADDR_BUFFER, 32'h0000_c000 + p);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_0093);
        xfer(1'b1, icc_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h0000_0001);
        xfer(1'b1, icc_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
        repeat (3) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0000);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_0000);
        // captures per interrupt, every code
        xfer(1'b1, icc_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, icc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
            xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0003 | (c << 5));
            i_pin.pulses(c, 4);
            repeat (10) @(posedge hclk);
            chk(32'(irq), 32'h0000_0000);
            i_pin.pulses(1, 4);
            repeat (10) @(posedge hclk);
            chk(32'(irq), 32'h0000_0001);
            for (int k = 0; k <= c; k++)
                xfer(1'b0, icc_pkg::ADDR_BUFFER, 32'h0000_0000);
            xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0000);
        end
        // wake from sleep in interrupt-only mode, then capture while idle
        cpu_sleep <= 1'b1;
        xfer(1'b1, icc_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0007);
        i_pin.pulses(2, 4);
        repeat (10) @(posedge hclk);
        chk(32'(wakes), 32'h0000_0002);
        rchk(icc_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_0007);
        cpu_sleep <= 1'b0;
        cpu_idle <= 1'b1;
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_0003);
        i_pin.pulses(1, 4);
        repeat (10) @(posedge hclk);
        chk(32'(wakes), 32'h0000_0003);
        // stop-in-idle: no capture, but the wake-only mode still wakes
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_2003);
        i_pin.pulses(1, 4);
        repeat (10) @(posedge hclk);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_200b);
        chk(32'(wakes), 32'h0000_0003);
        xfer(1'b1, icc_pkg::ADDR_CONTROL, 32'h0000_2007);
        i_pin.pulses(1, 4);
        repeat (10) @(posedge hclk);
        chk(32'(wakes), 32'h0000_0004);
        cpu_idle <= 1'b0;
        // second reset in mid-run
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'({irq, wake, hresp, hreadyout}), 32'h0000_0001);
        rchk(icc_pkg::ADDR_CONTROL, 32'h0000_0000);
        conclude();
    end
endmodule // tb
`default_nettype wire
